// ### logic/role_fsm_consts.svh
// constants for the redundant controller role machine
//
// Overview of operation
// - wait to standby needs run, online, primary peer on link, mismatches permitted
// - wait to primary needs online and primary permission from a stop-to-run transition
// - wait to primary also needs ring control or a linked peer not running
// - standby becomes primary when peer enters wait or standby
// - standby becomes primary when ring link and redundancy link are both lost
// - standby becomes primary when primary peer receives a swap command
// - standby drops to wait after 3 s link silence while ring link healthy
// - standby drops to wait on forbidden online change or firmware update
// - safety variant standby drops to wait on safe change without maintenance mode
// - primary drops to wait when all drops lost and standby peer reaches one
// - primary designated b drops to wait when b peer is primary
// - primary becomes standby when drops lost, peer reaches one, link healthy
// - primary becomes standby when a task halts and standby peer runs all
// - primary becomes standby on swap command while peer is standby
// - every primary to standby move also needs all mismatches permitted
// - any active role enters stop on a run to stop transition
// - primary to standby passes through wait for at least one scan
// - drops healthy while one is seen, unhealthy after 3 s with none
// - on simultaneous contention for primary with equal drop visibility the a designated controller wins
// - when only one controller sees a drop that one wins primary
`ifndef ROLE_FSM_CONSTS_SVH
`define ROLE_FSM_CONSTS_SVH

// register offsets
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_STATUS      8'h08

// command bits
`define CMD_SWAP_BIT    0
`define CMD_WARM_BIT    1

// reset values
`define CTRL_RESET      9'h000

// timing
`define CLOCK_PERIOD_NS 64'd8
`define SILENCE_MS      64'd3000
`define DROP_LOSS_MS    64'd3000
`define SILENCE_CYC     (`SILENCE_MS * 64'd1000000 / `CLOCK_PERIOD_NS)
`define DROP_LOSS_CYC   (`DROP_LOSS_MS * 64'd1000000 / `CLOCK_PERIOD_NS)

`endif

// ### logic/role_fsm_pkg.sv
// types shared by the role machine modules
package role_fsm_pkg;

    typedef enum logic [1:0] {
        ROLE_WAIT,
        ROLE_STANDBY,
        ROLE_PRIMARY,
        ROLE_STOP
    } role_t;

    typedef struct packed {
        logic designate_b;
        logic safety_variant;
        logic maint_mode;
        logic fw_update_allow;
        logic online_mod_allow;
        logic logic_mm_allow;
        logic fw_mm_allow;
        logic online;
        logic run;
    } ctrl_t;

    typedef struct packed {
        logic  primary_request;
        logic  pend_standby;
        logic  permit_primary;
        logic  link_silent;
        logic  drop_ok;
        role_t role;
    } status_t;

endpackage

// ### logic/role_ctl_if.sv
// carrier between the register port and the role machine
`timescale 1ns/1ns
interface role_ctl_if;
    import role_fsm_pkg::*;

    ctrl_t   ctrl;
    logic    swap_pulse;
    logic    warm_pulse;
    status_t status;

    modport regs (
        output ctrl,
        output swap_pulse,
        output warm_pulse,
        input  status
    );

    modport core (
        input  ctrl,
        input  swap_pulse,
        input  warm_pulse,
        output status
    );
endinterface

// ### logic/silence_timer.sv
// counts how long a health level has stayed low
`timescale 1ns/1ns
module silence_timer
    import role_fsm_pkg::*;
#(
    parameter int unsigned LIMIT = 32'd375000000
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic alive,
    output logic      expired
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        expired;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    // saturating, so a long outage never wraps back to healthy
    always_comb begin
        s_d = s_q;
        if (alive) begin
            s_d.cnt     = 32'h00000000;
            s_d.expired = 1'b0;
        end else if (s_q.cnt < LIMIT) begin
            s_d.cnt = s_q.cnt + 32'h00000001;
        end else begin
            s_d.expired = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.expired;

endmodule

// ### logic/role_reg_port.sv
// software register port for the role machine
`timescale 1ns/1ns
`include "role_fsm_consts.svh"
module role_reg_port
    import role_fsm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    role_ctl_if.regs         ctl
);

    typedef struct packed {
        ctrl_t       ctrl;
        logic        swap;
        logic        warm;
        logic [31:0] rdata;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.swap  = 1'b0;
        s_d.warm  = 1'b0;
        s_d.rdata = 32'h00000000;
        if (wr && addr == `OFS_CTRL) begin
            s_d.ctrl = ctrl_t'(wdata[8:0]);
        end
        // command writes are one-cycle pulses, nothing is stored
        if (wr && addr == `OFS_CMD) begin
            s_d.swap = wdata[`CMD_SWAP_BIT];
            s_d.warm = wdata[`CMD_WARM_BIT];
        end
        // unmapped addresses read as zero
        if (rd) begin
            case (addr)
                `OFS_CTRL:   s_d.rdata = {23'h000000, s_q.ctrl};
                `OFS_STATUS: s_d.rdata = {25'h0000000, ctl.status};
                default:     s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q      <= '0;
            s_q.ctrl <= ctrl_t'(`CTRL_RESET);
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata          = s_q.rdata;
    assign ctl.ctrl       = s_q.ctrl;
    assign ctl.swap_pulse = s_q.swap;
    assign ctl.warm_pulse = s_q.warm;

endmodule

// ### logic/redundant_controller_role_fsm.sv
// role state machine of one controller in a redundant pair
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "role_fsm_consts.svh"
module redundant_controller_role_fsm
    import role_fsm_pkg::*;
#(
    parameter int unsigned SILENCE_CYCLES   = 32'(`SILENCE_CYC),
    parameter int unsigned DROP_LOSS_CYCLES = 32'(`DROP_LOSS_CYC)
) (
    input  wire logic        clock,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // scan timing
    input  wire logic        scan_tick,
    // own health and application status
    input  wire logic        redundancy_link_alive,
    input  wire logic        ring_link_ok,
    input  wire logic        controls_ring,
    input  wire logic        drop_seen,
    input  wire logic        task_halted,
    input  wire logic        fw_mismatch,
    input  wire logic        logic_mismatch,
    input  wire logic        changes_exist,
    input  wire logic        fw_update_exist,
    input  wire logic        safe_change,
    // counterpart state received over the redundancy link
    input  wire role_t       peer_role,
    input  wire logic        peer_run,
    input  wire logic        peer_designate_b,
    input  wire logic        peer_drops_ok,
    input  wire logic        peer_all_tasks_run,
    input  wire logic        peer_maint_mode,
    input  wire logic        peer_swap_cmd,
    input  wire logic        peer_primary_request,
    // own state sent to the counterpart
    output role_t            role,
    output logic             primary_request
);

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------

    role_ctl_if ctl ();

    logic link_silent;
    logic drop_lost;

    role_reg_port u_regs (
        .clock (clock),
        .reset (reset),
        .addr  (addr),
        .wdata (wdata),
        .wr    (wr),
        .rd    (rd),
        .rdata (rdata),
        .ctl   (ctl.regs)
    );

    silence_timer #(
        .LIMIT (SILENCE_CYCLES)
    ) u_link_timer (
        .clock   (clock),
        .reset   (reset),
        .alive   (redundancy_link_alive),
        .expired (link_silent)
    );

    // drops stay healthy until none has been seen for the full window
    silence_timer #(
        .LIMIT (DROP_LOSS_CYCLES)
    ) u_drop_timer (
        .clock   (clock),
        .reset   (reset),
        .alive   (drop_seen),
        .expired (drop_lost)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------

    typedef struct packed {
        role_t role;
        logic  run_prev;
        logic  permit_primary;
        logic  swap_pend;
        logic  pend_standby;
        logic  primary_req;
    } fsm_state_t;

    fsm_state_t s_q;
    fsm_state_t s_d;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // every existing mismatch must carry its permission
    function automatic logic mismatches_ok(input ctrl_t c,
                                           input logic  fw_mm,
                                           input logic  logic_mm,
                                           input logic  changes);
        mismatches_ok = (!fw_mm || c.fw_mm_allow)
                     && (!logic_mm || c.logic_mm_allow)
                     && (!changes || c.online_mod_allow);
    endfunction

    // contention outcome: drop visibility first, then a/b designation
    function automatic logic wins_contention(input logic own_drops,
                                             input logic peer_drops,
                                             input logic own_b,
                                             input logic peer_req);
        if (!peer_req) begin
            wins_contention = 1'b1;
        end else if (own_drops != peer_drops) begin
            wins_contention = own_drops;
        end else begin
            wins_contention = !own_b;
        end
    endfunction

    // ------------------------------------------------------------------
    // condition terms
    // ------------------------------------------------------------------

    ctrl_t c;
    logic  drop_ok;
    logic  link_ok;
    logic  mm_ok;
    logic  run_rise;
    logic  run_fall;
    logic  want_primary;
    logic  go_standby_from_wait;
    logic  stby_to_wait_change;
    logic  stby_to_wait_safe;
    logic  stby_to_wait_silent;
    logic  stby_to_primary;
    logic  prim_to_wait;
    logic  prim_to_standby;

    always_comb begin
        c        = ctl.ctrl;
        drop_ok  = !drop_lost;
        link_ok  = !link_silent;
        mm_ok    = mismatches_ok(c, fw_mismatch, logic_mismatch, changes_exist);
        run_rise = c.run && !s_q.run_prev;
        run_fall = !c.run && s_q.run_prev;

        // wait to primary
        want_primary = c.online
                    && s_q.permit_primary
                    && (controls_ring || (link_ok && !peer_run));

        // wait to standby
        go_standby_from_wait = c.run
                            && c.online
                            && link_ok
                            && peer_role == ROLE_PRIMARY
                            && mm_ok;

        // standby to wait
        stby_to_wait_change = (changes_exist && !c.online_mod_allow)
                           || (fw_update_exist && !c.fw_update_allow);
        stby_to_wait_safe   = c.safety_variant
                           && safe_change
                           && !c.maint_mode
                           && !peer_maint_mode;
        stby_to_wait_silent = link_silent && ring_link_ok;

        // standby to primary; peer state only trusted while the link is alive
        stby_to_primary = (link_ok && (peer_role == ROLE_WAIT
                                       || peer_role == ROLE_STANDBY))
                       || (!ring_link_ok && link_silent)
                       || (link_ok && peer_role == ROLE_PRIMARY
                                   && peer_swap_cmd);

        // primary to wait
        prim_to_wait = (c.designate_b && peer_designate_b
                        && peer_role == ROLE_PRIMARY)
                    || (!drop_ok && peer_role == ROLE_STANDBY
                        && peer_drops_ok && !(link_ok && mm_ok));

        // primary to standby, always gated by the mismatch permissions
        prim_to_standby = mm_ok
                       && peer_role == ROLE_STANDBY
                       && ((!drop_ok && peer_drops_ok && link_ok)
                           || (task_halted && peer_all_tasks_run)
                           || s_q.swap_pend);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    always_comb begin
        s_d = s_q;

        // swap commands between scans are latched; a new command beats the scan clear
        if (scan_tick) begin
            s_d.swap_pend = 1'b0;
        end
        if (ctl.swap_pulse) begin
            s_d.swap_pend = 1'b1;
        end

        // the request is advertised continuously so the peer can arbitrate
        s_d.primary_req = (s_q.role == ROLE_WAIT) && want_primary;

        // transitions are only taken on the scan boundary
        if (scan_tick) begin
            s_d.run_prev = c.run;

            if (run_rise) begin
                s_d.permit_primary = 1'b1;
            end
            if (run_fall) begin
                s_d.permit_primary = 1'b0;
            end

            case (s_q.role)
                ROLE_STOP: begin
                    if (run_rise) begin
                        s_d.role = ROLE_WAIT;
                    end
                end
                ROLE_WAIT: begin
                    if (run_fall) begin
                        s_d.role         = ROLE_STOP;
                        s_d.pend_standby = 1'b0;
                    end else if (s_q.pend_standby && go_standby_from_wait) begin
                        // a full scan has been spent in wait
                        s_d.role         = ROLE_STANDBY;
                        s_d.pend_standby = 1'b0;
                    end else if (want_primary
                                 && wins_contention(drop_ok, peer_drops_ok,
                                                    c.designate_b,
                                                    peer_primary_request)) begin
                        s_d.role           = ROLE_PRIMARY;
                        s_d.permit_primary = 1'b0;
                    end else if (go_standby_from_wait) begin
                        s_d.role = ROLE_STANDBY;
                    end
                end
                ROLE_STANDBY: begin
                    // a forbidden or safe change outranks promotion, even on total loss; silence comes last
                    if (run_fall) begin
                        s_d.role = ROLE_STOP;
                    end else if (stby_to_wait_change || stby_to_wait_safe) begin
                        s_d.role = ROLE_WAIT;
                    end else if (stby_to_primary) begin
                        s_d.role = ROLE_PRIMARY;
                    end else if (stby_to_wait_silent) begin
                        s_d.role = ROLE_WAIT;
                    end
                end
                ROLE_PRIMARY: begin
                    if (run_fall) begin
                        s_d.role = ROLE_STOP;
                    end else if (prim_to_wait) begin
                        s_d.role = ROLE_WAIT;
                    end else if (prim_to_standby) begin
                        // standby is reached through one scan of wait
                        s_d.role         = ROLE_WAIT;
                        s_d.pend_standby = 1'b1;
                    end
                end
                default: begin
                    s_d.role = ROLE_STOP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------

    // start in stop so no controller claims outputs before software runs it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q      <= '0;
            s_q.role <= ROLE_STOP;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    assign role            = s_q.role;
    assign primary_request = s_q.primary_req;

    assign ctl.status.role            = s_q.role;
    assign ctl.status.drop_ok         = !drop_lost;
    assign ctl.status.link_silent     = link_silent;
    assign ctl.status.permit_primary  = s_q.permit_primary;
    assign ctl.status.pend_standby    = s_q.pend_standby;
    assign ctl.status.primary_request = s_q.primary_req;

endmodule

// ### sim/peer_model.sv
// counterpart controller model driving the peer status lines
`timescale 1ns/1ns
module peer_model
    import role_fsm_pkg::*;
(
    input  wire logic clock,
    output role_t     peer_role,
    output logic      peer_run,
    output logic      peer_designate_b,
    output logic      peer_drops_ok,
    output logic      peer_all_tasks_run,
    output logic      peer_maint_mode,
    output logic      peer_swap_cmd,
    output logic      peer_primary_request
);
    // -----------------------------------------------------------------
    // start-up: peer powered but stopped
    // -----------------------------------------------------------------
    initial begin
        peer_role = ROLE_STOP;
        {peer_run, peer_designate_b, peer_drops_ok, peer_all_tasks_run} = 4'h0;
        {peer_maint_mode, peer_swap_cmd, peer_primary_request} = 3'h0;
    end

    // -----------------------------------------------------------------
    // f: run, designate_b, drops_ok, all_tasks_run, maint, swap, request
    // lat > 0 models a slow counterpart scan
    // -----------------------------------------------------------------
    task automatic set_peer(input role_t r, input logic [6:0] f, input int lat);
        repeat (lat) @(posedge clock);
        @(posedge clock);
        peer_role <= r;
        {peer_run, peer_designate_b, peer_drops_ok} <= f[6:4];
        {peer_all_tasks_run, peer_maint_mode} <= f[3:2];
        // a swap only means something to a primary
        peer_swap_cmd <= f[1] && (r == ROLE_PRIMARY);
        peer_primary_request <= f[0];
    endtask
endmodule

// ### sim/role_fsm_sva.sv
// concurrent checks on the role machine ports
`timescale 1ns/1ns
`include "role_fsm_consts.svh"
module role_fsm_sva
    import role_fsm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] rdata,
    input  wire logic        scan_tick,
    input  wire logic        redundancy_link_alive,
    input  wire logic        controls_ring,
    input  wire logic        fw_mismatch,
    input  wire logic        logic_mismatch,
    input  wire logic        changes_exist,
    input  wire logic        fw_update_exist,
    input  wire logic        safe_change,
    input  wire role_t       peer_role,
    input  wire logic        peer_run,
    input  wire logic        peer_designate_b,
    input  wire role_t       role,
    input  wire logic        primary_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // -----------------------------------------------------------------
    // shadow of the control register, seen from the bus alone
    // -----------------------------------------------------------------
    ctrl_t ctrl_q;
    logic  run_scan_q;
    logic  mm_ok;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= '0;
            run_scan_q <= 1'b0;
        end else begin
            if (wr && addr == `OFS_CTRL)
                ctrl_q <= ctrl_t'(wdata[8:0]);
            if (scan_tick)
                run_scan_q <= ctrl_q.run;
        end
    end
    assign mm_ok = (!fw_mismatch || ctrl_q.fw_mm_allow) &&
                   (!logic_mismatch || ctrl_q.logic_mm_allow) &&
                   (!changes_exist || ctrl_q.online_mod_allow);

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_wait_scan;
        scan_tick && role == ROLE_WAIT;
    endsequence

    a_role_only_scan: assert property (!scan_tick |=> $stable(role))
        else $error("role moved without a scan");
    a_run_fall_stop: assert property (scan_tick && run_scan_q && !ctrl_q.run |=> role == ROLE_STOP)
        else $error("run fall did not stop");
    a_no_direct_standby: assert property (role == ROLE_PRIMARY |=> role != ROLE_STANDBY)
        else $error("primary went straight to standby");
    a_wait_standby_cond: assert property (s_wait_scan ##0 !(ctrl_q.run && ctrl_q.online &&
        peer_role == ROLE_PRIMARY && mm_ok) |=> role != ROLE_STANDBY)
        else $error("standby entered without its conditions");
    a_primary_online: assert property (s_wait_scan ##0 !ctrl_q.online |=> role != ROLE_PRIMARY)
        else $error("primary entered while offline");
    a_primary_ring: assert property (s_wait_scan ##0 (!controls_ring && peer_run)
        |=> role != ROLE_PRIMARY)
        else $error("primary entered without ring control");
    a_b_pair_wait: assert property (scan_tick && role == ROLE_PRIMARY && run_scan_q && ctrl_q.run &&
        ctrl_q.designate_b && peer_designate_b && peer_role == ROLE_PRIMARY
        |=> role == ROLE_WAIT)
        else $error("second b primary kept its role");
    a_link_ok_stays: assert property (scan_tick && role == ROLE_STANDBY && redundancy_link_alive &&
        $past(redundancy_link_alive) && !changes_exist && !fw_update_exist && !safe_change &&
        run_scan_q && ctrl_q.run |=> role != ROLE_WAIT)
        else $error("standby dropped while link alive");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside read answer");
    a_request_in_wait: assert property (primary_request |-> $past(role) == ROLE_WAIT)
        else $error("primary request outside wait");
endmodule

// ### sim/tb_redundant_controller_role_fsm.sv
// self-checking bench for the role machine
`timescale 1ns/1ns
`include "role_fsm_consts.svh"
module tb_redundant_controller_role_fsm
    import role_fsm_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0, scan_tick = 1'b0;
    logic        redundancy_link_alive = 1'b1, ring_link_ok = 1'b1, controls_ring = 1'b0;
    logic        drop_seen = 1'b1, task_halted = 1'b0, fw_mismatch = 1'b0;
    logic        logic_mismatch = 1'b0, changes_exist = 1'b0;
    logic        fw_update_exist = 1'b0, safe_change = 1'b0;
    logic [31:0] rdata;
    role_t       role, peer_role;
    logic        primary_request, peer_run, peer_designate_b, peer_drops_ok;
    logic        peer_all_tasks_run, peer_maint_mode, peer_swap_cmd, peer_primary_request;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    // short silence limits keep the run brief
    redundant_controller_role_fsm #(.SILENCE_CYCLES(20), .DROP_LOSS_CYCLES(20)) dut (.*);

    peer_model peer (.*);

    initial forever #4 clock = ~clock;

    // -----------------------------------------------------------------
    // access tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // role settles one clock after the scan edge
    task automatic scan(input role_t exp);
        @(posedge clock);
        scan_tick <= 1'b1;
        @(posedge clock);
        scan_tick <= 1'b0;
        #1 check(role, exp);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // scenarios; peer flags: run, b, drops, tasks, maint, swap, request
    // -----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1 check(role, ROLE_STOP);
        rd_reg(`OFS_CTRL, 32'h0);
        rd_reg(8'h0C, 32'h0);
        peer.set_peer(ROLE_STANDBY, 7'b1011001, 0);
        wr_reg(`OFS_CTRL, 32'h001);
        scan(ROLE_WAIT);
        scan(ROLE_WAIT);
        wr_reg(`OFS_CTRL, 32'h003);
        scan(ROLE_WAIT);
        controls_ring <= 1'b1;
        @(posedge clock);
        #1 check(primary_request, 1'b1);
        scan(ROLE_PRIMARY);
        fw_mismatch <= 1'b1;
        wr_reg(`OFS_CMD, 32'h1);
        scan(ROLE_PRIMARY);
        wr_reg(`OFS_CTRL, 32'h007);
        wr_reg(`OFS_CMD, 32'h1);
        scan(ROLE_WAIT);
        peer.set_peer(ROLE_PRIMARY, 7'b1011000, 3);
        scan(ROLE_STANDBY);
        peer.set_peer(ROLE_PRIMARY, 7'b1011010, 0);
        scan(ROLE_PRIMARY);
        peer.set_peer(ROLE_STANDBY, 7'b1011000, 0);
        task_halted <= 1'b1;
        scan(ROLE_WAIT);
        peer.set_peer(ROLE_PRIMARY, 7'b1011000, 0);
        task_halted <= 1'b0;
        scan(ROLE_STANDBY);
        peer.set_peer(ROLE_WAIT, 7'b1011000, 0);
        scan(ROLE_PRIMARY);
        wr_reg(`OFS_CTRL, 32'h107);
        peer.set_peer(ROLE_PRIMARY, 7'b1111000, 0);
        scan(ROLE_WAIT);
        wr_reg(`OFS_CTRL, 32'h087);
        peer.set_peer(ROLE_PRIMARY, 7'b1011000, 0);
        scan(ROLE_STANDBY);
        for (int i = 0; i < 3; i++) begin
            changes_exist <= (i == 0);
            fw_update_exist <= (i == 1);
            safe_change <= (i == 2);
            scan(ROLE_WAIT);
            {changes_exist, fw_update_exist, safe_change} <= 3'h0;
            scan(ROLE_STANDBY);
        end
        redundancy_link_alive <= 1'b0;
        repeat (14) @(posedge clock);
        scan(ROLE_STANDBY);
        repeat (8) @(posedge clock);
        scan(ROLE_WAIT);
        redundancy_link_alive <= 1'b1;
        scan(ROLE_STANDBY);
        redundancy_link_alive <= 1'b0;
        ring_link_ok <= 1'b0;
        repeat (25) @(posedge clock);
        scan(ROLE_PRIMARY);
        {redundancy_link_alive, ring_link_ok} <= 2'h3;
        peer.set_peer(ROLE_STANDBY, 7'b1011000, 0);
        drop_seen <= 1'b0;
        repeat (8) @(posedge clock);
        rd_reg(`OFS_STATUS, 32'h06);
        repeat (20) @(posedge clock);
        rd_reg(`OFS_STATUS, 32'h02);
        scan(ROLE_WAIT);
        peer.set_peer(ROLE_PRIMARY, 7'b1011000, 0);
        drop_seen <= 1'b1;
        scan(ROLE_STANDBY);
        wr_reg(`OFS_CTRL, 32'h000);
        scan(ROLE_STOP);
        wrap_up();
    end

    // a hang counts against the run
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
endmodule

bind redundant_controller_role_fsm role_fsm_sva u_sva (.*);
